// *** rtl/ocsr_pkg.sv ***
package ocsr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register addresses on the special function register bus
  localparam logic [7:0] SYSTEM_CLOCK_SELECT_ADDR = 8'hA9;
  localparam logic [7:0] LF_OSC_CONTROL_ADDR = 8'hB1;
  localparam logic [7:0] HF_OSC_TRIM_ADDR = 8'hC7;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int LF_EN_BIT = 7;
  localparam int LF_RDY_BIT = 6;
  localparam int LF_TRIM_MSB = 5;
  localparam int LF_TRIM_LSB = 2;
  localparam int LF_DIV_MSB = 1;
  localparam int LF_DIV_LSB = 0;
  localparam int SYS_DIV_MSB = 6;
  localparam int SYS_DIV_LSB = 4;
  localparam int SYS_SRC_MSB = 1;
  localparam int SYS_SRC_LSB = 0;

  ////////////////////////////////////////////////////////////////////////////
  // values after reset
  localparam logic [2:0] SYS_DIV_RST = 3'h3;
  localparam logic [1:0] SYS_SRC_RST = 2'h0;
  localparam logic LF_EN_RST = 1'b0;
  localparam logic [3:0] LF_TRIM_RST = 4'h0;
  localparam logic [1:0] LF_DIV_RST = 2'h0;
  localparam logic [7:0] HF_TRIM_RST = 8'h80;
  localparam logic [7:0] RDATA_RST = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser layout and counts
  localparam int SYNC_PINS = 4;
  localparam int PIN_HF = 0;
  localparam int PIN_EXT = 1;
  localparam int PIN_LF = 2;
  localparam int PIN_LF_SETTLED = 3;
  localparam int DIV_CNT_W = 7;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    OCSR_SRC_HF = 2'b00,
    OCSR_SRC_EXT = 2'b01,
    OCSR_SRC_LF = 2'b10,
    OCSR_SRC_RSVD = 2'b11
  } ocsr_src_t;

  typedef enum logic [0:0] {
    OCSR_TRIM_LOAD = 1'b0,
    OCSR_TRIM_RUN = 1'b1
  } ocsr_trim_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ocsr_sfr_req_t;

  typedef struct packed {
    logic enable;
    logic stable;
    logic [3:0] trim;
    logic [1:0] divider;
  } ocsr_lf_ctrl_t;

  typedef struct packed {
    logic [2:0] divider;
    ocsr_src_t source;
  } ocsr_sys_sel_t;

endpackage

// *** rtl/ocsr_pow2_div.sv ***
`timescale 1ns/1ps
module ocsr_pow2_div
  import ocsr_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // source level, already synchronised, and power of two
  input wire logic src_i,
  input wire logic [2:0] exp_i,
  // divided level
  output logic div_o
);

  logic src_prev_reg;
  logic src_prev_next;
  logic [DIV_CNT_W-1:0] cnt_reg;
  logic [DIV_CNT_W-1:0] cnt_next;
  logic div_reg;
  logic div_next;

  // each counter bit toggles at half the rate of the one below, so bit n-1
  // is the source divided by 2**n; code zero passes the source straight on
  always_comb begin
    src_prev_next = src_i;
    cnt_next = cnt_reg;
    if (src_i && !src_prev_reg) begin
      cnt_next = DIV_CNT_W'(cnt_reg + 1'b1);
    end
    if (exp_i == 3'h0) begin
      div_next = src_i;
    end else begin
      div_next = cnt_reg[exp_i - 3'h1];
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      src_prev_reg <= 1'b0;
      cnt_reg <= '0;
      div_reg <= 1'b0;
    end else if (ce_i) begin
      src_prev_reg <= src_prev_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
    end
  end

  assign div_o = div_reg;

endmodule

// *** rtl/ocsr_clock_regs.sv ***
`timescale 1ns/1ps
module ocsr_clock_regs
  import ocsr_pkg::*;
(
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // special function register bus
  input wire ocsr_sfr_req_t sfr_req_i,
  output logic [7:0] sfr_rdata_o,
  // oscillator and pin levels from outside this clock domain
  input wire logic hf_osc_raw_i,
  input wire logic external_clock_input_i,
  input wire logic lf_osc_raw_i,
  input wire logic lf_osc_settled_i,
  // factory calibration and watchdog state
  input wire logic [7:0] hf_trim_factory_i,
  input wire logic watchdog_active_i,
  // controls to the analog oscillators
  output logic [7:0] hf_osc_trim_o,
  output logic [3:0] lf_osc_trim_o,
  output logic lf_osc_run_o,
  // derived clocks
  output logic lf_osc_clk_o,
  output logic system_clock_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [SYNC_PINS-1:0] pin_raw;
  logic [SYNC_PINS-1:0] s1_reg;
  logic [SYNC_PINS-1:0] s2_reg;
  logic [SYNC_PINS-1:0] s3_reg;
  logic [SYNC_PINS-1:0] pin_reg;
  logic [SYNC_PINS-1:0] s1_next;
  logic [SYNC_PINS-1:0] s2_next;
  logic [SYNC_PINS-1:0] s3_next;
  logic [SYNC_PINS-1:0] pin_next;

  assign pin_raw[PIN_HF] = hf_osc_raw_i;
  assign pin_raw[PIN_EXT] = external_clock_input_i;
  assign pin_raw[PIN_LF] = lf_osc_raw_i;
  assign pin_raw[PIN_LF_SETTLED] = lf_osc_settled_i;

  // a new level is accepted only once the second and third stages agree,
  // which costs one cycle of latency but rejects single-cycle glitches
  for (genvar i = 0; i < SYNC_PINS; i++) begin : g_sync
    always_comb begin
      s1_next[i] = pin_raw[i];
      s2_next[i] = s1_reg[i];
      s3_next[i] = s2_reg[i];
      pin_next[i] = pin_reg[i];
      if (s2_reg[i] == s3_reg[i]) begin
        pin_next[i] = s3_reg[i];
      end
    end

    always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        s1_reg[i] <= 1'b0;
        s2_reg[i] <= 1'b0;
        s3_reg[i] <= 1'b0;
        pin_reg[i] <= 1'b0;
      end else if (ce_i) begin
        s1_reg[i] <= s1_next[i];
        s2_reg[i] <= s2_next[i];
        s3_reg[i] <= s3_next[i];
        pin_reg[i] <= pin_next[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  ocsr_trim_state_t trim_state_reg;
  ocsr_trim_state_t trim_state_next;
  logic [7:0] hf_trim_reg;
  logic [7:0] hf_trim_next;
  ocsr_lf_ctrl_t lf_ctrl_reg;
  ocsr_lf_ctrl_t lf_ctrl_next;
  ocsr_sys_sel_t sys_sel_reg;
  ocsr_sys_sel_t sys_sel_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic lf_run_reg;
  logic lf_run_next;
  logic lf_clk_prev_reg;
  logic lf_clk_prev_next;

  logic wr_sys;
  logic wr_lf;
  logic wr_hf;
  logic lf_div_change;
  logic lf_clk;
  logic lf_rise;

  assign wr_sys = sfr_req_i.wr && (sfr_req_i.addr == SYSTEM_CLOCK_SELECT_ADDR);
  assign wr_lf = sfr_req_i.wr && (sfr_req_i.addr == LF_OSC_CONTROL_ADDR);
  assign wr_hf = sfr_req_i.wr && (sfr_req_i.addr == HF_OSC_TRIM_ADDR);
  assign lf_div_change = wr_lf && (sfr_req_i.wdata[LF_DIV_MSB:LF_DIV_LSB] != lf_ctrl_reg.divider);
  assign lf_rise = lf_clk && !lf_clk_prev_reg;

  always_comb begin
    trim_state_next = trim_state_reg;
    hf_trim_next = hf_trim_reg;
    lf_ctrl_next = lf_ctrl_reg;
    sys_sel_next = sys_sel_reg;
    rdata_next = rdata_reg;
    lf_clk_prev_next = lf_clk;
    // the watchdog overrides a cleared enable so its time base never stops
    lf_run_next = lf_ctrl_reg.enable || watchdog_active_i;

    case (trim_state_reg)
      OCSR_TRIM_LOAD: begin
        // calibration is sampled once after reset release, never under reset
        hf_trim_next = hf_trim_factory_i;
        trim_state_next = OCSR_TRIM_RUN;
      end
      OCSR_TRIM_RUN: begin
        if (wr_hf) begin
          hf_trim_next = sfr_req_i.wdata;
        end
      end
      default: begin
        trim_state_next = OCSR_TRIM_LOAD;
      end
    endcase

    if (wr_lf) begin
      lf_ctrl_next.enable = sfr_req_i.wdata[LF_EN_BIT];
      // no interlock against trimming while running: a live change merely
      // disturbs the frequency, which software is expected to avoid
      lf_ctrl_next.trim = sfr_req_i.wdata[LF_TRIM_MSB:LF_TRIM_LSB];
      lf_ctrl_next.divider = sfr_req_i.wdata[LF_DIV_MSB:LF_DIV_LSB];
    end

    // the stable bit is never taken from the write data
    if (lf_div_change) begin
      lf_ctrl_next.stable = 1'b0;
    end else if (lf_run_reg && pin_reg[PIN_LF_SETTLED] && lf_rise) begin
      lf_ctrl_next.stable = 1'b1;
    end

    if (wr_sys) begin
      sys_sel_next.divider = sfr_req_i.wdata[SYS_DIV_MSB:SYS_DIV_LSB];
      // the reserved source code is refused so the clock never loses a source
      if (sfr_req_i.wdata[SYS_SRC_MSB:SYS_SRC_LSB] != OCSR_SRC_RSVD) begin
        sys_sel_next.source = ocsr_src_t'(sfr_req_i.wdata[SYS_SRC_MSB:SYS_SRC_LSB]);
      end
    end

    if (sfr_req_i.rd) begin
      case (sfr_req_i.addr)
        SYSTEM_CLOCK_SELECT_ADDR: begin
          rdata_next = {1'b0, sys_sel_reg.divider, 2'b00, sys_sel_reg.source};
        end
        LF_OSC_CONTROL_ADDR: begin
          rdata_next = lf_ctrl_reg;
        end
        HF_OSC_TRIM_ADDR: begin
          rdata_next = hf_trim_reg;
        end
        default: begin
          rdata_next = RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      trim_state_reg <= OCSR_TRIM_LOAD;
      hf_trim_reg <= HF_TRIM_RST;
      lf_ctrl_reg <= '{enable: LF_EN_RST, stable: 1'b0, trim: LF_TRIM_RST, divider: LF_DIV_RST};
      sys_sel_reg <= '{divider: SYS_DIV_RST, source: OCSR_SRC_HF};
      rdata_reg <= RDATA_RST;
      lf_run_reg <= 1'b0;
      lf_clk_prev_reg <= 1'b0;
    end else if (ce_i) begin
      trim_state_reg <= trim_state_next;
      hf_trim_reg <= hf_trim_next;
      lf_ctrl_reg <= lf_ctrl_next;
      sys_sel_reg <= sys_sel_next;
      rdata_reg <= rdata_next;
      lf_run_reg <= lf_run_next;
      lf_clk_prev_reg <= lf_clk_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock dividers

  logic [2:0] lf_exp;
  logic lf_src;
  logic sys_src;

  // divider code 00 means divide by eight, so the exponent is its inverse
  assign lf_exp = {1'b0, ~lf_ctrl_reg.divider};
  assign lf_src = pin_reg[PIN_LF] && lf_run_reg;

  always_comb begin
    case (sys_sel_reg.source)
      OCSR_SRC_HF: sys_src = pin_reg[PIN_HF];
      OCSR_SRC_EXT: sys_src = pin_reg[PIN_EXT];
      OCSR_SRC_LF: sys_src = lf_clk;
      default: sys_src = pin_reg[PIN_HF];
    endcase
  end

  ocsr_pow2_div u_lf_div (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .src_i(lf_src),
    .exp_i(lf_exp),
    .div_o(lf_clk)
  );

  ocsr_pow2_div u_sys_div (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .src_i(sys_src),
    .exp_i(sys_sel_reg.divider),
    .div_o(system_clock_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign sfr_rdata_o = rdata_reg;
  assign hf_osc_trim_o = hf_trim_reg;
  assign lf_osc_trim_o = lf_ctrl_reg.trim;
  assign lf_osc_run_o = lf_run_reg;
  assign lf_osc_clk_o = lf_clk;

endmodule

// *** test/ocsr_clock_regs_asserts.sv ***
`timescale 1ns/1ps
module ocsr_clock_regs_asserts
  import ocsr_pkg::*;
(
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_b_i,
  input wire logic ce_i,
  // register bus
  input wire ocsr_sfr_req_t sfr_req_i,
  input wire logic [7:0] sfr_rdata_o,
  // watchdog and controls
  input wire logic watchdog_active_i,
  input wire logic [7:0] hf_osc_trim_o,
  input wire logic [3:0] lf_osc_trim_o,
  input wire logic lf_osc_run_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  logic rd_t;
  logic wr_t;
  logic [7:0] a;
  assign rd_t = ce_i && sfr_req_i.rd;
  assign wr_t = ce_i && sfr_req_i.wr;
  assign a = sfr_req_i.addr;
  ////////////////////////////////////////////////////////////////////////////
  a_hf_trim_write: assert property (
    wr_t && a == HF_OSC_TRIM_ADDR |=> hf_osc_trim_o == $past(sfr_req_i.wdata))
    else $error("high trim missed a write");
  a_hf_trim_read: assert property (
    rd_t && a == HF_OSC_TRIM_ADDR |=> sfr_rdata_o == $past(hf_osc_trim_o))
    else $error("high trim read wrong");
  a_lf_trim_write: assert property (
    wr_t && a == LF_OSC_CONTROL_ADDR |=> lf_osc_trim_o == $past(sfr_req_i.wdata[5:2]))
    else $error("low trim missed a write");
  a_watchdog_run: assert property (
    ce_i && watchdog_active_i |=> lf_osc_run_o)
    else $error("low osc stopped under watchdog");
  a_select_rsvd_zero: assert property (
    rd_t && a == SYSTEM_CLOCK_SELECT_ADDR |=> !sfr_rdata_o[7] && sfr_rdata_o[3:2] == 2'h0)
    else $error("select reserved bits not zero");
  a_unmapped_zero: assert property (
    rd_t && a != SYSTEM_CLOCK_SELECT_ADDR && a != LF_OSC_CONTROL_ADDR && a != HF_OSC_TRIM_ADDR
    |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (
    !rd_t |=> $stable(sfr_rdata_o))
    else $error("read data moved without a read");
  // a frozen enable must hold both trim outputs, or software sees phantom writes
  a_ce_freeze: assert property (
    !ce_i |=> $stable(hf_osc_trim_o) && $stable(lf_osc_trim_o))
    else $error("registers moved with enable low");
endmodule

bind ocsr_clock_regs ocsr_clock_regs_asserts ocsr_clock_regs_asserts_inst (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .sfr_req_i(sfr_req_i),
  .sfr_rdata_o(sfr_rdata_o), .watchdog_active_i(watchdog_active_i),
  .hf_osc_trim_o(hf_osc_trim_o), .lf_osc_trim_o(lf_osc_trim_o), .lf_osc_run_o(lf_osc_run_o));

// *** test/ocsr_clock_regs_test.sv ***
`timescale 1ns/1ps
module ocsr_clock_regs_test;
  import ocsr_pkg::*;
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin miscompares++; \
  $display("FAIL %s expected %h seen %h", n, e, a); end end
  logic clock_i, rst_b_i, ce_i, watchdog_active_i, lf_osc_settled_i, p;
  ocsr_sfr_req_t sfr_req_i;
  logic [7:0] sfr_rdata_o, hf_osc_trim_o, q;
  logic [3:0] lf_osc_trim_o, pc;
  logic lf_osc_run_o, lf_osc_clk_o, system_clock_o;
  int miscompares, samples_checked, cycles, edges;
  // address, write data, value read back
  logic [23:0] rows [10] = '{24'hA9_70_70, 24'hA9_FD_71, 24'hA9_03_01, 24'hA9_02_02,
    24'hA9_00_00, 24'hB1_3C_3C, 24'hB1_40_00, 24'hC7_00_00, 24'hC7_FF_FF, 24'h55_12_00};
  // select value, system clock rising edges in 128 cycles
  logic [15:0] clk_rows [5] = '{16'h00_20, 16'h10_10, 16'h20_08, 16'h01_10, 16'h02_08};
  ocsr_clock_regs ocsr_clock_regs_inst (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .sfr_req_i(sfr_req_i),
    .sfr_rdata_o(sfr_rdata_o), .hf_osc_raw_i(pc[1]), .external_clock_input_i(pc[2]),
    .lf_osc_raw_i(pc[3]), .lf_osc_settled_i(lf_osc_settled_i), .hf_trim_factory_i(8'h5A),
    .watchdog_active_i(watchdog_active_i), .hf_osc_trim_o(hf_osc_trim_o),
    .lf_osc_trim_o(lf_osc_trim_o), .lf_osc_run_o(lf_osc_run_o),
    .lf_osc_clk_o(lf_osc_clk_o), .system_clock_o(system_clock_o));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 0;
    forever #10 clock_i = ~clock_i;
  end
  // oscillator pins: high period 4, external 8, low 16 cycles
  always @(negedge clock_i) pc <= pc + 4'h1;
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task io(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_i);
    sfr_req_i = '{a, w, r, d};
    @(negedge clock_i);
    sfr_req_i = '0;
    q = sfr_rdata_o;
  endtask
  task rst_seq;
    rst_b_i = 0;
    repeat (6) @(negedge clock_i);
    `CHK("trim in reset", 8'h80, hf_osc_trim_o)
    rst_b_i = 1;
    repeat (2) @(negedge clock_i);
  endtask
  // sampled on the falling edge so the count never races the output flop
  task measure;
    repeat (16) @(negedge clock_i);
    edges = 0;
    p = system_clock_o;
    repeat (128) begin
      @(negedge clock_i);
      if (system_clock_o && !p) edges++;
      p = system_clock_o;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b_i = 0;
    ce_i = 1;
    watchdog_active_i = 0;
    lf_osc_settled_i = 1;
    sfr_req_i = '0;
    pc = 4'h0;
    rst_seq();
    io(0, 1, 8'hA9, 8'h00);
    `CHK("select reset", 8'h30, q)
    io(0, 1, 8'hB1, 8'h00);
    `CHK("low ctrl reset", 8'h00, q)
    io(0, 1, 8'hC7, 8'h00);
    `CHK("high trim reset", 8'h5A, q)
    measure();
    `CHK("reset clock", 1'b1, edges >= 3 && edges <= 5)
    foreach (rows[i]) begin
      io(1, 0, rows[i][23:16], rows[i][15:8]);
      io(0, 1, rows[i][23:16], 8'h00);
      `CHK("register row", rows[i][7:0], q)
    end
    io(1, 0, 8'hB1, 8'h83);
    repeat (80) @(negedge clock_i);
    io(0, 1, 8'hB1, 8'h00);
    `CHK("low stable", 8'hC3, q)
    `CHK("low run", 1'b1, lf_osc_run_o)
    foreach (clk_rows[i]) begin
      io(1, 0, 8'hA9, clk_rows[i][15:8]);
      measure();
      `CHK("clock rate", 1'b1, edges + 1 >= clk_rows[i][7:0] && edges <= clk_rows[i][7:0] + 1)
    end
    // system clock still follows the low clock, so its rate shows the low divider
    io(1, 0, 8'hB1, 8'h82);
    measure();
    `CHK("low divide two", 1'b1, edges >= 3 && edges <= 5)
    // back to divide by one; the divider change clears stable, the measure lets it set again
    io(1, 0, 8'hB1, 8'h83);
    measure();
    `CHK("low divide one", 1'b1, edges >= 7 && edges <= 9)
    io(1, 0, 8'hB1, 8'h03);
    io(0, 1, 8'hB1, 8'h00);
    `CHK("stable after disable", 8'h43, q)
    `CHK("low stopped", 1'b0, lf_osc_run_o)
    `CHK("low clock gated", 1'b0, lf_osc_clk_o)
    watchdog_active_i = 1;
    repeat (3) @(negedge clock_i);
    `CHK("watchdog run", 1'b1, lf_osc_run_o)
    watchdog_active_i = 0;
    io(1, 0, 8'hB1, 8'h03);
    io(0, 1, 8'hB1, 8'h00);
    `CHK("same divider", 8'h43, q)
    io(1, 0, 8'hB1, 8'h02);
    io(0, 1, 8'hB1, 8'h00);
    `CHK("divider change", 8'h02, q)
    ce_i = 0;
    io(1, 0, 8'hC7, 8'h11);
    ce_i = 1;
    io(0, 1, 8'hC7, 8'h00);
    `CHK("frozen write", 8'hFF, q)
    `CHK("frozen trim pins", 8'hFF, hf_osc_trim_o)
    rst_seq();
    io(0, 1, 8'hA9, 8'h00);
    `CHK("select second reset", 8'h30, q)
    print_verdict();
  end
endmodule
